// ### udct_regs.svh
// Contract
// - each instance holds a 16-bit count as separate low and high bytes.
// - modes are autoreload, capture and toggle output; captures happen only while counting up.
// - control bits select capture or reload; configuration bits enable toggle output.
// - timer can drive a square wave onto an output pin.
// - select bit clear: count advances on the internal timer clock source.
// - select bit set: each falling edge on count pin steps count by one.
// - clock select picks system_clock, system_clock/2, system_clock/12 or crystal clock/8.
// - decrement enable set: direction pin 1 counts up, 0 counts down.
// - with decrement enable set, direction pin never triggers capture or reload.
// - instances 0 and 1 trigger conversions; all three schedule converter updates.
// - each overflow is a baud source for serial port 0 only, never port 1.
`ifndef UDCT_REGS_SVH
`define UDCT_REGS_SVH
`define UDCT_NUM_TMR 3
`define UDCT_NUM_ADC_TRIG 2
`define UDCT_CNT_MAX 16'hFFFF
`define UDCT_CNT_MIN 16'h0000
`define UDCT_CNT_RST 16'h0000
`define UDCT_DIV2_LAST 4'h1
`define UDCT_DIV12_LAST 4'hB
`define UDCT_DIV8_LAST 3'h7
`define UDCT_CTL_RST 8'h00
`define UDCT_CFG_RST 8'h00
// control register fields
`define UDCT_CTL_CAP_RLD 0
`define UDCT_CTL_CT_SEL 1
`define UDCT_CTL_RUN 2
`define UDCT_CTL_EXT_EN 3
// configuration register fields
`define UDCT_CFG_CKSEL0 3
`define UDCT_CFG_CKSEL1 4
`define UDCT_CFG_TOG_EN 1
`define UDCT_CFG_DCEN 0
`endif

// ### udct_pkg.sv
package udct_pkg;
    typedef enum logic [1:0] {
        UDCT_CK_SYS = 2'h0,
        UDCT_CK_DIV2 = 2'h1,
        UDCT_CK_DIV12 = 2'h2,
        UDCT_CK_XTAL8 = 2'h3
    } udct_cksel_t;

    typedef struct packed {
        logic [7:0] lo;
        logic [7:0] hi;
        logic lo_we;
        logic hi_we;
        logic [7:0] ctl;
        logic [7:0] cfg;
        logic ctl_we;
        logic cfg_we;
        logic ovf_clr;
    } udct_sw_t;

    typedef struct packed {
        logic [7:0] count_low_byte;
        logic [7:0] count_high_byte;
        logic [7:0] cap_lo;
        logic [7:0] cap_hi;
        logic ovf;
        logic ext_flag;
    } udct_st_t;
endpackage : udct_pkg

// ### udct_timer.sv
`timescale 1ns/1ps
`include "udct_regs.svh"
module udct_timer
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // crystal clock sample, synchronous to mclk
    input wire logic crystal_pin_in,
    // software access per instance
    input udct_pkg::udct_sw_t sw [`UDCT_NUM_TMR],
    output udct_pkg::udct_st_t st [`UDCT_NUM_TMR],
    // pins per instance
    input wire logic [`UDCT_NUM_TMR-1:0] count_input_pin,
    input wire logic [`UDCT_NUM_TMR-1:0] direction_input_pin,
    output logic [`UDCT_NUM_TMR-1:0] toggle_out,
    // system events
    output logic [`UDCT_NUM_ADC_TRIG-1:0] adc_start,
    output logic [`UDCT_NUM_TMR-1:0] dac_update,
    output logic [`UDCT_NUM_TMR-1:0] uart0_baud_tick
);
    import udct_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // shared prescalers
    logic [3:0] div2_q;
    logic [3:0] div12_q;
    logic [2:0] div8_q;
    logic xt_s1_q;
    logic xt_s2_q;
    logic xt_s3_q;
    logic xt_rise;

    assign xt_rise = xt_s2_q & ~xt_s3_q;

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            div2_q <= 4'h0;
            div12_q <= 4'h0;
        end
        else
        begin
            div2_q <= (div2_q == `UDCT_DIV2_LAST) ? 4'h0 : div2_q + 4'h1;
            div12_q <= (div12_q == `UDCT_DIV12_LAST) ? 4'h0 : div12_q + 4'h1;
        end
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            xt_s1_q <= 1'b0;
            xt_s2_q <= 1'b0;
            xt_s3_q <= 1'b0;
            div8_q <= 3'h0;
        end
        else
        begin
            xt_s1_q <= crystal_pin_in;
            xt_s2_q <= xt_s1_q;
            xt_s3_q <= xt_s2_q;
            if (xt_rise)
                div8_q <= div8_q + 3'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // per instance timers
    genvar g;
    generate
        for (g = 0; g < `UDCT_NUM_TMR; g++)
        begin : gen_tmr
            logic [15:0] cnt_q;
            logic [15:0] rld_q;
            logic [7:0] ctl_q;
            logic [7:0] cfg_q;
            logic ovf_q;
            logic exf_q;
            logic tog_q;
            logic ovf_p_q;
            logic ct_s1_q, ct_s2_q, ct_s3_q;
            logic dr_s1_q, dr_s2_q, dr_s3_q;
            logic tick;
            logic up;
            logic wrap;
            logic ext_evt;
            udct_cksel_t cksel;

            // two-flop synchronisers plus a history stage
            always_ff @(posedge mclk or negedge rst_b)
            begin
                if (!rst_b)
                begin
                    ct_s1_q <= 1'b1;
                    ct_s2_q <= 1'b1;
                    ct_s3_q <= 1'b1;
                    dr_s1_q <= 1'b1;
                    dr_s2_q <= 1'b1;
                    dr_s3_q <= 1'b1;
                end
                else
                begin
                    ct_s1_q <= count_input_pin[g];
                    ct_s2_q <= ct_s1_q;
                    ct_s3_q <= ct_s2_q;
                    dr_s1_q <= direction_input_pin[g];
                    dr_s2_q <= dr_s1_q;
                    dr_s3_q <= dr_s2_q;
                end
            end

            assign cksel = udct_cksel_t'({cfg_q[`UDCT_CFG_CKSEL1], cfg_q[`UDCT_CFG_CKSEL0]});

            always_comb
            begin
                if (ctl_q[`UDCT_CTL_CT_SEL])
                    tick = ~ct_s2_q & ct_s3_q;
                else
                begin
                    unique case (cksel)
                        UDCT_CK_SYS: tick = 1'b1;
                        UDCT_CK_DIV2: tick = (div2_q == `UDCT_DIV2_LAST);
                        UDCT_CK_DIV12: tick = (div12_q == `UDCT_DIV12_LAST);
                        UDCT_CK_XTAL8: tick = xt_rise && (div8_q == `UDCT_DIV8_LAST);
                    endcase
                end
                tick = tick & ctl_q[`UDCT_CTL_RUN];
            end

            // direction pin only steers direction when decrement is enabled
            assign up = cfg_q[`UDCT_CFG_DCEN] ? dr_s2_q : 1'b1;
            assign ext_evt = ~cfg_q[`UDCT_CFG_DCEN] & ctl_q[`UDCT_CTL_EXT_EN]
                & ~dr_s2_q & dr_s3_q;
            assign wrap = tick & (up ? (cnt_q == `UDCT_CNT_MAX) : (cnt_q == rld_q));

            always_ff @(posedge mclk or negedge rst_b)
            begin
                if (!rst_b)
                begin
                    ctl_q <= `UDCT_CTL_RST;
                    cfg_q <= `UDCT_CFG_RST;
                end
                else
                begin
                    if (sw[g].ctl_we)
                        ctl_q <= sw[g].ctl;
                    if (sw[g].cfg_we)
                        cfg_q <= sw[g].cfg;
                end
            end

            // counter
            always_ff @(posedge mclk or negedge rst_b)
            begin
                if (!rst_b)
                begin
                    cnt_q <= `UDCT_CNT_RST;
                end
                else
                begin
                    if (wrap)
                        cnt_q <= up ? rld_q : `UDCT_CNT_MAX;
                    else if (tick)
                        cnt_q <= up ? cnt_q + 16'h1 : cnt_q - 16'h1;
                    else if (ext_evt && !ctl_q[`UDCT_CTL_CAP_RLD])
                        cnt_q <= rld_q;
                    if (sw[g].lo_we)
                        cnt_q[7:0] <= sw[g].lo;
                    if (sw[g].hi_we)
                        cnt_q[15:8] <= sw[g].hi;
                end
            end

            // reload/capture register
            always_ff @(posedge mclk or negedge rst_b)
            begin
                if (!rst_b)
                    rld_q <= `UDCT_CNT_RST;
                else if (ext_evt && ctl_q[`UDCT_CTL_CAP_RLD])
                    rld_q <= cnt_q;
            end

            // flags: set wins over clear
            always_ff @(posedge mclk or negedge rst_b)
            begin
                if (!rst_b)
                begin
                    ovf_q <= 1'b0;
                    exf_q <= 1'b0;
                end
                else
                begin
                    ovf_q <= wrap | (ovf_q & ~sw[g].ovf_clr);
                    exf_q <= ext_evt | (exf_q & ~sw[g].ovf_clr);
                end
            end

            // square wave output
            always_ff @(posedge mclk or negedge rst_b)
            begin
                if (!rst_b)
                    tog_q <= 1'b0;
                else if (wrap && cfg_q[`UDCT_CFG_TOG_EN])
                    tog_q <= ~tog_q;
            end

            // overflow events leave one cycle after the wrap
            always_ff @(posedge mclk or negedge rst_b)
            begin
                if (!rst_b)
                    ovf_p_q <= 1'b0;
                else
                    ovf_p_q <= wrap;
            end

            assign toggle_out[g] = tog_q;
            assign dac_update[g] = ovf_p_q;
            assign uart0_baud_tick[g] = ovf_p_q;
            assign st[g] = '{count_low_byte: cnt_q[7:0], count_high_byte: cnt_q[15:8],
                cap_lo: rld_q[7:0], cap_hi: rld_q[15:8], ovf: ovf_q, ext_flag: exf_q};
            if (g < `UDCT_NUM_ADC_TRIG)
            begin : gen_adc
                assign adc_start[g] = ovf_p_q;
            end
        end
    endgenerate
endmodule : udct_timer

// ### udct_timer_assertions.sv
`timescale 1ns/1ps
`include "udct_regs.svh"
module udct_timer_assertions
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // software access
    input udct_pkg::udct_sw_t sw [`UDCT_NUM_TMR],
    input udct_pkg::udct_st_t st [`UDCT_NUM_TMR],
    // events
    input wire logic [`UDCT_NUM_TMR-1:0] toggle_out,
    input wire logic [`UDCT_NUM_ADC_TRIG-1:0] adc_start,
    input wire logic [`UDCT_NUM_TMR-1:0] dac_update,
    input wire logic [`UDCT_NUM_TMR-1:0] uart0_baud_tick
);
    import udct_pkg::*;
    logic [7:0] ctl0_q;
    logic [7:0] cfg0_q;
    wire logic [15:0] cnt0 = {st[0].count_high_byte, st[0].count_low_byte};
    wire logic nowr0 = !sw[0].lo_we && !sw[0].hi_we;
    // shadow of instance 0 mode bits
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            ctl0_q <= 8'h00;
        else if (sw[0].ctl_we)
            ctl0_q <= sw[0].ctl;
    end
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            cfg0_q <= 8'h00;
        else if (sw[0].cfg_we)
            cfg0_q <= sw[0].cfg;
    end
    ////////////////////////////////////////////////////////////
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    lo_write_a: assert property (sw[0].lo_we |=> st[0].count_low_byte == $past(sw[0].lo))
        else $error("low byte write lost");
    hi_write_a: assert property (sw[0].hi_we |=> st[0].count_high_byte == $past(sw[0].hi))
        else $error("high byte write lost");
    sys_count_a: assert property (ctl0_q == 8'h04 && $stable(ctl0_q) && cfg0_q == 8'h00
        && nowr0 && cnt0 != 16'hFFFF |=> cnt0 == $past(cnt0) + 16'h1)
        else $error("timer missed a system tick");
    stop_hold_a: assert property (!ctl0_q[2] && !ctl0_q[3] && $stable(ctl0_q) && nowr0
        |=> $stable(cnt0))
        else $error("stopped count moved");
    half_rate_a: assert property (ctl0_q == 8'h04 && cfg0_q == 8'h08 && nowr0
        && $past(nowr0) && $changed(cnt0) |=> $stable(cnt0))
        else $error("halved clock ticked twice");
    ovf_event_a: assert property (dac_update[0] |-> st[0].ovf)
        else $error("event without flag");
    adc_pair_a: assert property (adc_start == dac_update[1:0])
        else $error("conversion start mismatch");
    baud_pair_a: assert property (uart0_baud_tick == dac_update)
        else $error("baud tick mismatch");
    toggle_wrap_a: assert property ($changed(toggle_out[0]) |-> ##[0:1] dac_update[0])
        else $error("toggle without wrap");
endmodule : udct_timer_assertions
bind udct_timer udct_timer_assertions u_chk (.mclk, .rst_b, .sw, .st, .toggle_out,
    .adc_start, .dac_update, .uart0_baud_tick);

// ### udct_pins.sv
`timescale 1ns/1ps
module udct_pins
(
    // clock
    input wire logic mclk,
    // requests
    input wire logic [2:0] fall_go,
    input wire logic [2:0] dir_lvl,
    // pins
    output logic [2:0] count_input_pin,
    output logic [2:0] direction_input_pin
);
    logic [2:0] low_q [3] = '{default: 3'h0};
    // pin held low four cycles per request
    always @(posedge mclk)
    begin
        for (int i = 0; i < 3; i++)
        begin
            if (fall_go[i])
                low_q[i] <= 3'h4;
            else if (low_q[i] != 3'h0)
                low_q[i] <= low_q[i] - 3'h1;
        end
    end
    always_comb
    begin
        for (int i = 0; i < 3; i++)
            count_input_pin[i] = low_q[i] == 3'h0;
    end
    assign direction_input_pin = dir_lvl;
endmodule : udct_pins

// ### udct_timer_bench.sv
`timescale 1ns/1ps
`include "udct_regs.svh"
module udct_timer_bench;
    import udct_pkg::*;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic crystal_pin_in = 1'b0;
    logic [2:0] fall_go = 3'h0;
    logic [2:0] dir_lvl = 3'h7;
    logic [2:0] count_input_pin, direction_input_pin, toggle_out, dac_update, uart0_baud_tick;
    logic [1:0] adc_start;
    udct_sw_t sw [`UDCT_NUM_TMR] = '{default: '0};
    udct_st_t st [`UDCT_NUM_TMR];
    int error_cnt = 0;
    int checks_done = 0;
    int div [4] = '{1, 2, 12, 16};
    wire logic [15:0] cnt = {st[0].count_high_byte, st[0].count_low_byte};
    wire logic [15:0] cap = {st[0].cap_hi, st[0].cap_lo};
    always #2 mclk = ~mclk;
    always @(posedge mclk) crystal_pin_in <= ~crystal_pin_in;
    udct_timer uut (.mclk, .rst_b, .crystal_pin_in, .sw, .st, .count_input_pin,
        .direction_input_pin, .toggle_out, .adc_start, .dac_update, .uart0_baud_tick);
    udct_pins pins (.mclk, .fall_go, .dir_lvl, .count_input_pin, .direction_input_pin);
    ////////////////////////////////////////////////////////////
    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : step
    task automatic wr(input logic [4:0] we, input logic [7:0] ctl, cfg, hi, lo);
        @(posedge mclk);
        sw[0] <= {lo, hi, we[0], we[1], ctl, cfg, we[2], we[3], we[4]};
        @(posedge mclk);
        sw[0] <= '0;
        #1;
    endtask : wr
    task automatic fall(input int n);
        repeat (n)
        begin
            @(posedge mclk);
            fall_go <= 3'h1;
            @(posedge mclk);
            fall_go <= 3'h0;
            step(8);
        end
    endtask : fall
    task automatic dir(input logic v);
        @(posedge mclk);
        dir_lvl <= {2'h3, v};
        step(8);
    endtask : dir
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic give_verdict;
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : give_verdict
    ////////////////////////////////////////////////////////////
    initial
    begin
        int n;
        int d;
        repeat (20) @(posedge mclk);
        rst_b <= 1'b1;
        step(1);
        check({st[0].ovf, st[0].ext_flag, toggle_out}, 5'h0);
        check({cnt, cap}, 32'h0);
        wr(5'h03, 8'h00, 8'h00, 8'hA5, 8'h3C);
        check(cnt, 16'hA53C);
        wr(5'h0F, 8'h04, 8'h02, 8'hFF, 8'hFC);
        for (n = 0; n < 20 && dac_update[0] !== 1'b1; n++)
            step(1);
        check({st[0].ovf, toggle_out[0], adc_start[0], uart0_baud_tick[0]}, 4'hF);
        wr(5'h1C, 8'h00, 8'h00, 8'h00, 8'h00);
        check(st[0].ovf, 1'b0);
        for (int m = 0; m < 4; m++)
        begin
            wr(5'h0F, 8'h00, {3'h0, m[1:0], 3'h0}, 8'h00, 8'h00);
            wr(5'h04, 8'h04, 8'h00, 8'h00, 8'h00);
            step(190);
            wr(5'h04, 8'h00, 8'h00, 8'h00, 8'h00);
            d = int'(cnt) - 192 / div[m];
            check(d >= -2 && d <= 2, 1'b1);
        end
        wr(5'h0F, 8'h06, 8'h00, 8'h00, 8'h00);
        fall(3);
        check(cnt, 16'h3);
        wr(5'h08, 8'h00, 8'h01, 8'h00, 8'h00);
        dir(1'b0);
        fall(2);
        check(cnt, 16'h1);
        wr(5'h04, 8'h0E, 8'h00, 8'h00, 8'h00);
        dir(1'b1);
        dir(1'b0);
        check({cap, cnt}, 32'h1);
        wr(5'h0C, 8'h0F, 8'h00, 8'h00, 8'h00);
        dir(1'b1);
        dir(1'b0);
        check(cap, 16'h1);
        wr(5'h07, 8'h0E, 8'h00, 8'h00, 8'h55);
        dir(1'b1);
        dir(1'b0);
        check(cnt, 16'h1);
        // instances 1 and 2 start one tick short of the wrap
        @(posedge mclk);
        sw[1] <= {8'hFF, 8'hFF, 2'h3, 8'h04, 8'h02, 3'h6};
        sw[2] <= {8'hFF, 8'hFF, 2'h3, 8'h04, 8'h02, 3'h6};
        @(posedge mclk);
        sw[1] <= '0;
        sw[2] <= '0;
        step(1);
        check({adc_start[1], dac_update[2:1], uart0_baud_tick[2:1]}, 5'h1F);
        check(toggle_out[2:1], 2'h3);
        give_verdict;
    end
    initial
    begin
        #20000;
        error_cnt++;
        give_verdict;
    end
endmodule : udct_timer_bench
